// *** design/oledps_pkg.sv ***
package oledps_pkg;

   // ********************************************************************
   // Geometry of the pixel memory
   // ********************************************************************
   localparam int unsigned COLS      = 128;
   localparam int unsigned ROWS      = 160;
   localparam int unsigned SUB_W     = 6;
   localparam int unsigned PIX_W     = 3 * SUB_W;
   localparam int unsigned COL_AW    = 7;
   localparam int unsigned ROW_AW    = 8;
   localparam logic [6:0]  COL_LAST  = 7'h7F;
   localparam logic [7:0]  ROW_LAST  = 8'h9F;

   // ********************************************************************
   // Command codes carried with data/command select low
   // ********************************************************************
   localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
   localparam logic [7:0] CMD_SLEEP_IN  = 8'h10;
   localparam logic [7:0] CMD_REMAP     = 8'hA0;
   localparam logic [7:0] CMD_MEM_WRITE = 8'h5C;
   localparam int unsigned REMAP_COL_BIT = 0;
   localparam int unsigned REMAP_ROW_BIT = 1;

   // ********************************************************************
   // Timing, in nanoseconds, and derived cycle counts at 25 MHz
   // ********************************************************************
   localparam longint unsigned CLK_NS       = 40;
   localparam longint unsigned T_VDD_NS     = 1_000_000;
   localparam longint unsigned T_RST_NS     = 2_000;
   localparam longint unsigned T_VCC_ON_NS  = 2_000;
   localparam longint unsigned T_WAKE_NS    = 200_000_000;
   localparam longint unsigned T_OFF_NS     = 100_000_000;
   // Least times round up.
   localparam int unsigned VDD_CYC    = int'((T_VDD_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned RST_CYC    = int'((T_RST_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned VCC_ON_CYC = int'((T_VCC_ON_NS + CLK_NS - 1) / CLK_NS);
   localparam int unsigned OFF_CYC    = int'((T_OFF_NS + CLK_NS - 1) / CLK_NS);
   // A longest time rounds down.
   localparam int unsigned WAKE_CYC   = int'(T_WAKE_NS / CLK_NS);
   localparam int unsigned VCC_STABLE_CYC = 250;

   typedef enum logic [1:0] {
      OLEDPS_EXP_CMD,
      OLEDPS_EXP_REMAP,
      OLEDPS_EXP_PIXEL
   } oledps_expect_t;

endpackage : oledps_pkg

// *** design/oledps_if.sv ***
`timescale 1ns/10ps
`default_nettype none
// Pins between the host controller and the display module.
interface oledps_if;
   logic       module_reset_low;   // Active low module reset.
   logic       cs_n;               // Chip select, active low.
   logic       dc;                 // High means data, low means command.
   logic       wr;                 // One-cycle write strobe.
   logic [7:0] data;               // Byte being transferred.
   logic       panel_supply_en;    // Panel drive supply switch.

   modport host (output module_reset_low, output cs_n, output dc, output wr,
                 output data, output panel_supply_en);
   modport dev  (input module_reset_low, input cs_n, input dc, input wr,
                 input data, input panel_supply_en);
endinterface : oledps_if
`default_nettype wire

// *** design/oledps_dev.sv ***
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - Pixel memory 128 columns by 160 rows.
// - Pixel is three six-bit sub-pixels.
// - Column and row mapping software reversible.
// - Host waits 1 ms before reset.
// - Host holds reset low at least 2 us.
// - Panel supply on 2 us after reset; the host enables it in the same cycle as it releases reset.
// - Host sends sleep-exit 11h after supply.
// - Outputs on within 200 ms of wake.
// - Sleep-entry 10h before supply off.
// - Wait configurable interval before logic off.
// - Module reset input is active low.
// - Select low command, high data.
// - Chip select active low every transfer.
module oledps_dev #(
   parameter int unsigned WAKE_CYCLES = oledps_pkg::WAKE_CYC
) (
   input  wire logic                           i_sys_clk,
   input  wire logic                           i_rstn,
   oledps_if.dev                               bus,
   input  wire logic [oledps_pkg::COL_AW-1:0]  i_scan_col,
   input  wire logic [oledps_pkg::ROW_AW-1:0]  i_scan_row,
   output logic      [oledps_pkg::PIX_W-1:0]   o_pixel,
   output logic                                o_panel_on,
   output logic                                o_sleeping,
   output logic                                o_col_remap,
   output logic                                o_row_remap
);
   import oledps_pkg::*;

   // ********************************************************************
   // Storage and state
   // ********************************************************************
   // pixel memory array
   logic [PIX_W-1:0]  mem [0:COLS*ROWS-1];
   oledps_expect_t    exp_r, exp_nxt;
   logic              sleep_r, sleep_nxt;
   logic              on_r, on_nxt;
   logic [31:0]       wake_r, wake_nxt;
   logic [1:0]        remap_r, remap_nxt;
   logic [COL_AW-1:0] col_r, col_nxt;
   logic [ROW_AW-1:0] row_r, row_nxt;
   logic [1:0]        sub_r, sub_nxt;
   logic [2*SUB_W-1:0] acc_r, acc_nxt;
   logic              we;
   logic [PIX_W-1:0]  wdata;
   logic              take;

   // Flat index into the memory from a column and a row.
   function automatic logic [14:0] addr_of(input logic [COL_AW-1:0] c, input logic [ROW_AW-1:0] r);
      addr_of = 15'(r) * 15'(COLS) + 15'(c);
   endfunction : addr_of

   assign take = bus.wr & ~bus.cs_n;

   // ********************************************************************
   // Command decode, memory write pointer and wake timer
   // ********************************************************************
   // Module reset acts synchronously here; the host holds it far longer than a cycle.
   always_comb begin
      exp_nxt   = exp_r;
      sleep_nxt = sleep_r;
      on_nxt    = on_r;
      wake_nxt  = wake_r;
      remap_nxt = remap_r;
      col_nxt   = col_r;
      row_nxt   = row_r;
      sub_nxt   = sub_r;
      acc_nxt   = acc_r;
      we        = 1'b0;
      wdata     = {acc_r, bus.data[SUB_W-1:0]};
      if (!sleep_r && !on_r) begin
         if (wake_r >= WAKE_CYCLES - 1) begin
            on_nxt = 1'b1;
         end else begin
            wake_nxt = wake_r + 32'h0000_0001;
         end
      end
      if (take && !bus.dc) begin
         exp_nxt = OLEDPS_EXP_CMD;
         case (bus.data)
            CMD_SLEEP_OUT: begin
               if (sleep_r) begin
                  sleep_nxt = 1'b0;
                  wake_nxt  = 32'h0000_0000;
               end
            end
            CMD_SLEEP_IN: begin
               sleep_nxt = 1'b1;
               on_nxt    = 1'b0;
            end
            CMD_REMAP: exp_nxt = OLEDPS_EXP_REMAP;
            CMD_MEM_WRITE: begin
               exp_nxt = OLEDPS_EXP_PIXEL;
               col_nxt = '0;
               row_nxt = '0;
               sub_nxt = 2'h0;
            end
            default: exp_nxt = OLEDPS_EXP_CMD;
         endcase
      end else if (take) begin
         case (exp_r)
            OLEDPS_EXP_REMAP: begin
               remap_nxt = {bus.data[REMAP_ROW_BIT], bus.data[REMAP_COL_BIT]};
               exp_nxt   = OLEDPS_EXP_CMD;
            end
            OLEDPS_EXP_PIXEL: begin
               if (sub_r == 2'h2) begin
                  we      = 1'b1;
                  sub_nxt = 2'h0;
                  if (col_r == COL_LAST) begin
                     col_nxt = '0;
                     row_nxt = (row_r == ROW_LAST) ? '0 : row_r + 8'h01;
                  end else begin
                     col_nxt = col_r + 7'h01;
                  end
               end else begin
                  acc_nxt = {acc_r[SUB_W-1:0], bus.data[SUB_W-1:0]};
                  sub_nxt = sub_r + 2'h1;
               end
            end
            default: exp_nxt = OLEDPS_EXP_CMD;
         endcase
      end
      // Panel can't light without its drive supply.
      if (!bus.panel_supply_en) begin
         on_nxt = 1'b0;
      end
      if (!bus.module_reset_low) begin
         exp_nxt   = OLEDPS_EXP_CMD;
         sleep_nxt = 1'b1;
         on_nxt    = 1'b0;
         wake_nxt  = 32'h0000_0000;
         remap_nxt = 2'h0;
         col_nxt   = '0;
         row_nxt   = '0;
         sub_nxt   = 2'h0;
         acc_nxt   = '0;
         we        = 1'b0;
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         exp_r   <= OLEDPS_EXP_CMD;
         sleep_r <= 1'b1;
         on_r    <= 1'b0;
         wake_r  <= 32'h0000_0000;
         remap_r <= 2'h0;
         col_r   <= '0;
         row_r   <= '0;
         sub_r   <= 2'h0;
         acc_r   <= '0;
      end else begin
         exp_r   <= exp_nxt;
         sleep_r <= sleep_nxt;
         on_r    <= on_nxt;
         wake_r  <= wake_nxt;
         remap_r <= remap_nxt;
         col_r   <= col_nxt;
         row_r   <= row_nxt;
         sub_r   <= sub_nxt;
         acc_r   <= acc_nxt;
      end
   end

   // ********************************************************************
   // Memory write port and scan read port
   // ********************************************************************
   // Memory has no reset so it can map onto block RAM.
   always_ff @(posedge i_sys_clk) begin
      if (we) begin
         mem[addr_of(col_r, row_r)] <= wdata;
      end
   end

   logic [COL_AW-1:0] scan_c;
   logic [ROW_AW-1:0] scan_r;
   assign scan_r = remap_r[1] ? ROW_LAST - i_scan_row : i_scan_row;
   assign scan_c = remap_r[0] ? COL_LAST - i_scan_col : i_scan_col;

   logic [PIX_W-1:0] pix_r;
   // Blank pixels are shown while the outputs are off.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         pix_r <= '0;
      end else begin
         pix_r <= on_r ? mem[addr_of(scan_c, scan_r)] : '0;
      end
   end

   assign o_pixel     = pix_r;
   assign o_panel_on  = on_r;
   assign o_sleeping  = sleep_r;
   assign o_col_remap = remap_r[0];
   assign o_row_remap = remap_r[1];

endmodule : oledps_dev
`default_nettype wire

// *** design/oledps_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module oledps_host #(
   parameter int unsigned VDD_CYCLES  = oledps_pkg::VDD_CYC,
   parameter int unsigned WAKE_CYCLES = oledps_pkg::WAKE_CYC,
   parameter int unsigned OFF_CYCLES  = oledps_pkg::OFF_CYC,
   parameter int unsigned VCC_CYCLES  = oledps_pkg::VCC_STABLE_CYC
) (
   input  wire logic        i_sys_clk,
   input  wire logic        i_rstn,
   oledps_if.host           bus,
   input  wire logic        i_power_up,
   input  wire logic        i_power_down,
   input  wire logic        i_xfer_valid,
   input  wire logic        i_xfer_dc,
   input  wire logic [7:0]  i_xfer_byte,
   output logic             o_xfer_ready,
   output logic             o_io_supply_en,
   output logic             o_ready
);
   import oledps_pkg::*;

   typedef enum {
      ST_OFF, ST_IO_WAIT, ST_RST_LOW, ST_VCC_WAIT, ST_SEND_OUT,
      ST_WAKE_WAIT, ST_ON, ST_SEND_IN, ST_OFF_WAIT
   } oledps_hstate_t;

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   oledps_hstate_t st_r, st_nxt;
   logic [31:0]    cnt_r, cnt_nxt;
   logic           rst_r, rst_nxt, vcc_r, vcc_nxt, io_r, io_nxt;
   logic           cs_r, cs_nxt, dc_r, dc_nxt, wr_r, wr_nxt;
   logic [7:0]     dat_r, dat_nxt;
   logic           done;

   assign done = (cnt_r == 32'h0000_0000);
   assign o_xfer_ready = (st_r == ST_ON) && !i_power_down;

   always_comb begin
      st_nxt  = st_r;
      cnt_nxt = done ? cnt_r : cnt_r - 32'h0000_0001;
      rst_nxt = rst_r;
      vcc_nxt = vcc_r;
      io_nxt  = io_r;
      cs_nxt  = 1'b1;
      dc_nxt  = dc_r;
      wr_nxt  = 1'b0;
      dat_nxt = dat_r;
      case (st_r)
         ST_OFF: begin
            if (i_power_up) begin
               io_nxt  = 1'b1;
               cnt_nxt = 32'(VDD_CYCLES);
               st_nxt  = ST_IO_WAIT;
            end
         end
         ST_IO_WAIT: begin
            if (done) begin
               rst_nxt = 1'b0;
               cnt_nxt = 32'(RST_CYC);
               st_nxt  = ST_RST_LOW;
            end
         end
         ST_RST_LOW: begin
            if (done) begin
               rst_nxt = 1'b1;
               vcc_nxt = 1'b1;
               cnt_nxt = 32'(VCC_CYCLES);
               st_nxt  = ST_VCC_WAIT;
            end
         end
         ST_VCC_WAIT: begin
            if (done) begin
               st_nxt = ST_SEND_OUT;
            end
         end
         ST_SEND_OUT: begin
            cs_nxt  = 1'b0;
            dc_nxt  = 1'b0;
            wr_nxt  = 1'b1;
            dat_nxt = CMD_SLEEP_OUT;
            cnt_nxt = 32'(WAKE_CYCLES);
            st_nxt  = ST_WAKE_WAIT;
         end
         ST_WAKE_WAIT: begin
            if (done) begin
               st_nxt = ST_ON;
            end
         end
         ST_ON: begin
            if (i_power_down) begin
               st_nxt = ST_SEND_IN;
            end else if (i_xfer_valid) begin
               cs_nxt  = 1'b0;
               dc_nxt  = i_xfer_dc;
               wr_nxt  = 1'b1;
               dat_nxt = i_xfer_byte;
            end
         end
         ST_SEND_IN: begin
            cs_nxt  = 1'b0;
            dc_nxt  = 1'b0;
            wr_nxt  = 1'b1;
            dat_nxt = CMD_SLEEP_IN;
            cnt_nxt = 32'(OFF_CYCLES);
            st_nxt  = ST_OFF_WAIT;
         end
         ST_OFF_WAIT: begin
            vcc_nxt = 1'b0;
            if (done) begin
               io_nxt = 1'b0;
               st_nxt = ST_OFF;
            end
         end
         default: st_nxt = ST_OFF;
      endcase
   end

   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_r  <= ST_OFF;
         cnt_r <= 32'h0000_0000;
         rst_r <= 1'b1;
         vcc_r <= 1'b0;
         io_r  <= 1'b0;
         cs_r  <= 1'b1;
         dc_r  <= 1'b1;
         wr_r  <= 1'b0;
         dat_r <= 8'h00;
      end else begin
         st_r  <= st_nxt;
         cnt_r <= cnt_nxt;
         rst_r <= rst_nxt;
         vcc_r <= vcc_nxt;
         io_r  <= io_nxt;
         cs_r  <= cs_nxt;
         dc_r  <= dc_nxt;
         wr_r  <= wr_nxt;
         dat_r <= dat_nxt;
      end
   end

   assign bus.module_reset_low = rst_r;
   assign bus.panel_supply_en  = vcc_r;
   assign bus.cs_n             = cs_r;
   assign bus.dc               = dc_r;
   assign bus.wr               = wr_r;
   assign bus.data             = dat_r;
   assign o_io_supply_en       = io_r;
   assign o_ready              = (st_r == ST_ON);

endmodule : oledps_host
`default_nettype wire

// *** tb/oledps_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// Watches the pins between the host controller and the display module.
module oledps_asserts
   import oledps_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_rstn,
   input  wire logic       module_reset_low,
   input  wire logic       cs_n,
   input  wire logic       dc,
   input  wire logic       wr,
   input  wire logic [7:0] data,
   input  wire logic       panel_supply_en
);
   // ****************************************************************
   // Helper logic
   // ****************************************************************
   logic [7:0] low_cnt_r;
   logic [7:0] low_cnt_nxt;

   // Counts cycles of module reset held low, saturating so a stuck reset never wraps.
   always_comb begin
      low_cnt_nxt = 8'h00;
      if (!module_reset_low) begin
         low_cnt_nxt = (low_cnt_r == 8'hFF) ? low_cnt_r : low_cnt_r + 8'h01;
      end
   end

   // Registers the count.
   always_ff @(posedge i_sys_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         low_cnt_r <= 8'h00;
      end else begin
         low_cnt_r <= low_cnt_nxt;
      end
   end

   // ****************************************************************
   // Properties
   // ****************************************************************
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rstn);

   sequence s_supply_up;
      $rose(panel_supply_en);
   endsequence
   sequence s_wake_cmd;
      wr && !cs_n && !dc && (data == CMD_SLEEP_OUT);
   endsequence

   a_cs_with_strobe: assert property ((wr || !cs_n) |-> (wr && !cs_n))
      else $error("chip select and write strobe disagree");
   a_reset_min_width: assert property ($rose(module_reset_low) |-> (low_cnt_r >= RST_CYC))
      else $error("module reset pulse too short");
   a_reset_released: assert property ($fell(module_reset_low) |-> ##[50:52] module_reset_low)
      else $error("module reset not released in time");
   a_supply_at_release: assert property (s_supply_up |-> $rose(module_reset_low))
      else $error("panel supply enabled away from reset release");
   // The window assumes the bench shortens the supply settle count to five cycles.
   a_wake_after_supply: assert property (s_supply_up |-> ##[5:7] s_wake_cmd)
      else $error("sleep exit command missing after panel supply");
   a_sleep_before_off: assert property ($fell(panel_supply_en) |-> ($past(wr) && !$past(dc) && ($past(data) == CMD_SLEEP_IN)))
      else $error("panel supply dropped without sleep entry");
   a_no_xfer_reset: assert property (!module_reset_low |-> (!wr && cs_n))
      else $error("transfer while module held in reset");
   a_no_xfer_unpowered: assert property (!panel_supply_en |-> !wr)
      else $error("transfer while panel supply off");
endmodule : oledps_asserts
`default_nettype wire

// *** tb/tb_oled_module_power_sequencer.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("mismatch t=%0t got %h exp %h", $time, (got), (exp)); end end
module tb_oled_module_power_sequencer;
   import oledps_pkg::*;
   // Long counts are shortened so the run stays brief.
   localparam int unsigned VDD  = 20;
   localparam int unsigned WAKE = 30;
   localparam int unsigned OFF  = 10;
   localparam int unsigned VCC  = 5;

   logic        i_sys_clk    = 1'b0;
   logic        i_rstn       = 1'b0;
   logic        i_power_up   = 1'b0;
   logic        i_power_down = 1'b0;
   logic        xfer_valid   = 1'b0;
   logic        xfer_dc      = 1'b0;
   logic [7:0]  xfer_byte    = 8'h00;
   logic [6:0]  scan_col     = 7'h00;
   logic [7:0]  scan_row     = 8'h00;
   logic        o_xfer_ready, o_io_supply_en, o_ready;
   logic [17:0] o_pixel;
   logic        o_panel_on, o_sleeping, o_col_remap, o_row_remap;
   int          error_cnt  = 0;
   int          num_checks = 0;

   oledps_if oledps_if_inst ();

   oledps_host #(.VDD_CYCLES(VDD), .WAKE_CYCLES(WAKE), .OFF_CYCLES(OFF), .VCC_CYCLES(VCC)) oledps_host_inst (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .bus(oledps_if_inst), .i_power_up(i_power_up),
      .i_power_down(i_power_down), .i_xfer_valid(xfer_valid), .i_xfer_dc(xfer_dc),
      .i_xfer_byte(xfer_byte), .o_xfer_ready(o_xfer_ready), .o_io_supply_en(o_io_supply_en),
      .o_ready(o_ready));

   oledps_dev #(.WAKE_CYCLES(WAKE)) oledps_dev_inst (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .bus(oledps_if_inst), .i_scan_col(scan_col),
      .i_scan_row(scan_row), .o_pixel(o_pixel), .o_panel_on(o_panel_on), .o_sleeping(o_sleeping),
      .o_col_remap(o_col_remap), .o_row_remap(o_row_remap));

   oledps_asserts oledps_asserts_inst (
      .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .module_reset_low(oledps_if_inst.module_reset_low),
      .cs_n(oledps_if_inst.cs_n), .dc(oledps_if_inst.dc), .wr(oledps_if_inst.wr),
      .data(oledps_if_inst.data), .panel_supply_en(oledps_if_inst.panel_supply_en));

   // Free running 25 MHz clock.
   always #20 i_sys_clk = ~i_sys_clk;

   // ****************************************************************
   // Shared tasks
   // ****************************************************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done

   // Holds the request until an edge sees ready high, then releases it.
   task automatic send(input logic dc, input logic [7:0] b);
      @(posedge i_sys_clk);
      xfer_valid <= 1'b1;
      xfer_dc    <= dc;
      xfer_byte  <= b;
      do @(negedge i_sys_clk); while (o_xfer_ready !== 1'b1);
      @(posedge i_sys_clk);
      xfer_valid <= 1'b0;
   endtask : send

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_power_up;
      int n;
      // Look between edges so the first checks never race a register update.
      @(negedge i_sys_clk);
      `CHK({oledps_if_inst.module_reset_low, oledps_if_inst.panel_supply_en}, 2'b10)
      `CHK(o_panel_on, 1'b0)
      @(posedge i_sys_clk) i_power_up <= 1'b1;
      @(posedge i_sys_clk) i_power_up <= 1'b0;
      while (o_io_supply_en !== 1'b1) @(negedge i_sys_clk);
      n = 0;
      while (oledps_if_inst.module_reset_low !== 1'b0) begin @(negedge i_sys_clk); n++; end
      `CHK(n, VDD + 1)
      n = 0;
      while (oledps_if_inst.module_reset_low !== 1'b1) begin @(negedge i_sys_clk); n++; end
      `CHK(n, RST_CYC + 1)
      `CHK(oledps_if_inst.panel_supply_en, 1'b1)
      while (oledps_if_inst.wr !== 1'b1) @(negedge i_sys_clk);
      `CHK({oledps_if_inst.cs_n, oledps_if_inst.dc, oledps_if_inst.data}, {2'b00, CMD_SLEEP_OUT})
      n = 0;
      while (o_panel_on !== 1'b1) begin @(negedge i_sys_clk); n++; end
      `CHK(n inside {[WAKE - 1:WAKE + 1]}, 1'b1)
      while (o_ready !== 1'b1) @(negedge i_sys_clk);
      `CHK(o_sleeping, 1'b0)
      $display("test power_up finished");
   endtask : t_power_up

   // Two pixels at the memory origin, seen through every mapping mode.
   task automatic t_remap;
      logic [17:0] px [2];
      logic [1:0]  m;
      int          k;
      px[0] = {6'h3F, 6'h00, 6'h15};
      px[1] = {6'h01, 6'h20, 6'h2A};
      send(1'b0, CMD_MEM_WRITE);
      // Upper two bits set on purpose: only the low six may be stored.
      for (k = 0; k < 6; k++) send(1'b1, {2'b11, px[k / 3][17 - 6 * (k % 3) -: 6]});
      for (k = 0; k < 4; k++) begin
         m = k[1:0];
         send(1'b0, CMD_REMAP);
         send(1'b1, {6'h00, m});
         repeat (3) @(negedge i_sys_clk);
         `CHK({o_row_remap, o_col_remap}, m)
         @(posedge i_sys_clk);
         scan_col <= m[0] ? COL_LAST : 7'h00;
         scan_row <= m[1] ? ROW_LAST : 8'h00;
         @(posedge i_sys_clk);
         @(negedge i_sys_clk);
         `CHK(o_pixel, px[0])
         @(posedge i_sys_clk) scan_col <= m[0] ? 7'h7E : 7'h01;
         @(posedge i_sys_clk);
         @(negedge i_sys_clk);
         `CHK(o_pixel, px[1])
      end
      $display("test remap finished");
   endtask : t_remap

   task automatic t_power_down;
      logic [8:0] last;
      int         n;
      @(posedge i_sys_clk) i_power_down <= 1'b1;
      @(posedge i_sys_clk) i_power_down <= 1'b0;
      last = 9'h000;
      while (oledps_if_inst.panel_supply_en !== 1'b0) begin
         @(negedge i_sys_clk);
         if (oledps_if_inst.wr === 1'b1) last = {oledps_if_inst.dc, oledps_if_inst.data};
      end
      `CHK(last, {1'b0, CMD_SLEEP_IN})
      `CHK({o_sleeping, o_panel_on}, 2'b10)
      n = 0;
      while (o_io_supply_en !== 1'b0) begin @(negedge i_sys_clk); n++; end
      `CHK(n >= OFF, 1'b1)
      // A request while powered down must be refused.
      @(posedge i_sys_clk);
      xfer_valid <= 1'b1;
      xfer_byte  <= CMD_SLEEP_OUT;
      repeat (4) begin
         @(negedge i_sys_clk);
         `CHK({o_ready, o_xfer_ready, oledps_if_inst.wr}, 3'b000)
      end
      @(posedge i_sys_clk) xfer_valid <= 1'b0;
      $display("test power_down finished");
   endtask : t_power_down

   // Main sequence: reset, two full power cycles with the mapping test in the first.
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_rstn <= 1'b1;
      @(negedge i_sys_clk);
      t_power_up();
      t_remap();
      t_power_down();
      t_power_up();
      t_power_down();
      test_done();
   end

   // Watchdog: the whole sequence needs well under a thousand cycles.
   initial begin
      #(40 * 5000);
      error_cnt++;
      test_done();
   end
endmodule : tb_oled_module_power_sequencer
`default_nettype wire
